// ---- gpbw_pkg.sv ----
// gpbw_pkg: constants, register map and carrier types for the gpio pad, boot and wake block
package gpbw_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int PIN_CNT = 8;
  localparam int SRC_CNT = PIN_CNT + 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CFG_W = 4;
  localparam int BOOT_PIN_IDX = 5;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_PORT_IN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_OUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_SET = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_CLR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PORT_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WAKE_FILT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_WAKE_SEL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_WAKE_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DBG_STAT = 8'h24;

  // ****************************************************************
  // pin configuration codes, one 4-bit field per pin
  // ****************************************************************
  localparam logic [CFG_W-1:0] CFG_ANALOG = 4'h0;
  localparam logic [CFG_W-1:0] CFG_IN_FLOAT = 4'h1;
  localparam logic [CFG_W-1:0] CFG_IN_PULL = 4'h2;
  localparam logic [CFG_W-1:0] CFG_OUT_PP = 4'h3;
  localparam logic [CFG_W-1:0] CFG_OUT_OD = 4'h4;
  localparam logic [CFG_W-1:0] CFG_ALT_PP = 4'h5;
  localparam logic [CFG_W-1:0] CFG_ALT_OD = 4'h6;
  localparam logic [DATA_W-1:0] CFG_RST = 32'h11111111;

  // ****************************************************************
  // wake source bit positions (filter, select and status registers)
  // ****************************************************************
  localparam int WSRC_PINS = 0;
  localparam int WSRC_SC1 = 1;
  localparam int WSRC_SC2 = 2;
  localparam int WSRC_IRQ4 = 3;
  localparam int WSRC_W = 4;

  // debug status bits
  localparam int DBG_BOOT_BIT = 0;
  localparam int DBG_MONITOR_BIT = 1;
  localparam int DBG_DONE_BIT = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int BOOT_HOLD_FAST_CYC = 512;
  localparam int MONITOR_CHECK_US = 3000;
  localparam int MONITOR_CHECK_CYC = MONITOR_CHECK_US * CLK_MHZ;
  localparam int FILT_SAMPLES = 3;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gpbw_bus_req_type;

  typedef struct packed {
    logic [PIN_CNT-1:0] out;
    logic [PIN_CNT-1:0] oe;
    logic [PIN_CNT-1:0] pu_en;
    logic [PIN_CNT-1:0] pd_en;
  } gpbw_pad_ctl_type;

  typedef enum logic [3:0] {
    BS_HOLD = 4'b0001,
    BS_SAMPLE = 4'b0010,
    BS_CHECK = 4'b0100,
    BS_DONE = 4'b1000
  } gpbw_boot_state_type;
endpackage : gpbw_pkg

// ---- gpbw_top.sv ----
// gpbw_top: gpio pad control, boot strap sampling and deep sleep wake monitor
//
// Overview of operation
// - strap sequence runs only after a pin or always-on power reset.
// - during reset and 512 fast oscillator cycles, boot pin is pulled-up input.
// - sample boot pin after delay; high gives normal start, low gives monitor.
// - in monitor, recheck boot pin after 3 ms; stay only if still low.
// - after sampling, boot pin falls back to a floating input.
// - sampled strap level held in readable status bit until next qualifying reset.
// - analog mode: drivers and pulls off, input reads as 1.
// - floating input: pulls and drivers off.
// - pull input: output bit 0 selects pull-down, 1 selects pull-up.
// - input mode: pin level read by software and passed to peripherals.
// - output mode drives output bit, push-pull or open-drain, pulls off.
// - set and clear registers change chosen output bits atomically.
// - drive 0 sinks; drive 1 releases in open-drain, sources in push-pull.
// - output register reads back last written value, not pin level.
// - alternate output driven by peripheral, pulls off, input still readable.
// - pin levels captured at sleep entry; enabled pin change wakes device.
// - any level change wakes; no edge or level selection.
// - wake status records pin activity, not which pin.
// - filter enable bits for pins, both serial controllers and interrupt four.
// - filtered source wakes after three equal slow samples unlike captured level.
// - pin wake needs pin select bit; analog pins never wake.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
module gpbw_top
  import gpbw_pkg::*;
#(
  parameter int MONITOR_CYC = MONITOR_CHECK_CYC,
  parameter int HOLD_CYC = BOOT_HOLD_FAST_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic boot_qual_rst_n,
  input wire logic fast_rc_oscillator,
  input wire logic slow_rc_oscillator,
  input wire gpbw_pkg::gpbw_bus_req_type bus_req,
  output logic [gpbw_pkg::DATA_W-1:0] rd_data,
  input wire logic [gpbw_pkg::PIN_CNT-1:0] pad_in,
  output gpbw_pkg::gpbw_pad_ctl_type pad_ctl,
  input wire logic [gpbw_pkg::PIN_CNT-1:0] periph_out,
  output logic [gpbw_pkg::PIN_CNT-1:0] periph_in,
  input wire logic serial_one_activity,
  input wire logic serial_two_activity,
  input wire logic irq_four_in,
  input wire logic deep_sleep,
  output logic wake_req,
  output logic boot_monitor_active,
  output logic boot_seq_done
);
  import gpbw_pkg::*;

  localparam int MON_W = $clog2(MONITOR_CYC + 1);
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic [PIN_CNT-1:0] pin_s1_q;
  logic [PIN_CNT-1:0] pin_s2_q;
  logic [2:0] ext_s1_q;
  logic [2:0] ext_s2_q;
  logic [2:0] fosc_q;
  logic [2:0] sosc_q;

  // every asynchronous level passes two flops before use
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ext_s1_q <= '0;
      ext_s2_q <= '0;
    end else begin
      pin_s1_q <= pad_in;
      pin_s2_q <= pin_s1_q;
      ext_s1_q <= {irq_four_in, serial_two_activity, serial_one_activity};
      ext_s2_q <= ext_s1_q;
    end
  end

  // oscillator edges: third stage only feeds the edge detector
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fosc_q <= '0;
      sosc_q <= '0;
    end else begin
      fosc_q <= {fosc_q[1:0], fast_rc_oscillator};
      sosc_q <= {sosc_q[1:0], slow_rc_oscillator};
    end
  end

  logic fosc_tick;
  logic sosc_tick;
  assign fosc_tick = fosc_q[1] & ~fosc_q[2];
  assign sosc_tick = sosc_q[1] & ~sosc_q[2];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [PIN_CNT-1:0] out_q;
  logic [DATA_W-1:0] cfg_q;
  logic [PIN_CNT-1:0] wake_en_q;
  logic [WSRC_W-1:0] filt_q;
  logic [WSRC_W-1:0] sel_q;
  logic [WSRC_W-1:0] wstat_q;
  logic [WSRC_W-1:0] wstat_set;
  logic [DATA_W-1:0] rd_data_q;
  logic [PIN_CNT-1:0] in_lvl;
  logic [PIN_CNT-1:0] is_analog;
  logic boot_strap_q;
  gpbw_boot_state_type boot_state_q;

  logic wr_out;
  logic wr_set;
  logic wr_clr;
  assign wr_out = bus_req.wr && (bus_req.addr == OFS_PORT_OUT);
  assign wr_set = bus_req.wr && (bus_req.addr == OFS_PORT_SET);
  assign wr_clr = bus_req.wr && (bus_req.addr == OFS_PORT_CLR);

  // output bits: plain write, or atomic set/clear of selected bits only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
    end else if (wr_out) begin
      out_q <= bus_req.wdata[PIN_CNT-1:0];
    end else if (wr_set) begin
      out_q <= out_q | bus_req.wdata[PIN_CNT-1:0];
    end else if (wr_clr) begin
      out_q <= out_q & ~bus_req.wdata[PIN_CNT-1:0];
    end
  end

  // configuration and wake control registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CFG_RST;
      wake_en_q <= '0;
      filt_q <= '0;
      sel_q <= '0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == OFS_PORT_CFG) begin
        cfg_q <= bus_req.wdata;
      end else if (bus_req.addr == OFS_WAKE_EN) begin
        wake_en_q <= bus_req.wdata[PIN_CNT-1:0];
      end else if (bus_req.addr == OFS_WAKE_FILT) begin
        filt_q <= bus_req.wdata[WSRC_W-1:0];
      end else if (bus_req.addr == OFS_WAKE_SEL) begin
        sel_q <= bus_req.wdata[WSRC_W-1:0];
      end
    end
  end

  // wake status: write one to clear, a new wake in the same cycle wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wstat_q <= '0;
    end else if (bus_req.wr && (bus_req.addr == OFS_WAKE_STAT)) begin
      wstat_q <= (wstat_q & ~bus_req.wdata[WSRC_W-1:0]) | wstat_set;
    end else begin
      wstat_q <= wstat_q | wstat_set;
    end
  end

  // read mux, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else if (bus_req.rd) begin
      rd_data_q <= '0;
      if (bus_req.addr == OFS_PORT_IN) begin
        rd_data_q[PIN_CNT-1:0] <= in_lvl;
      end else if (bus_req.addr == OFS_PORT_OUT) begin
        rd_data_q[PIN_CNT-1:0] <= out_q;
      end else if (bus_req.addr == OFS_PORT_CFG) begin
        rd_data_q <= cfg_q;
      end else if (bus_req.addr == OFS_WAKE_EN) begin
        rd_data_q[PIN_CNT-1:0] <= wake_en_q;
      end else if (bus_req.addr == OFS_WAKE_FILT) begin
        rd_data_q[WSRC_W-1:0] <= filt_q;
      end else if (bus_req.addr == OFS_WAKE_SEL) begin
        rd_data_q[WSRC_W-1:0] <= sel_q;
      end else if (bus_req.addr == OFS_WAKE_STAT) begin
        rd_data_q[WSRC_W-1:0] <= wstat_q;
      end else if (bus_req.addr == OFS_DBG_STAT) begin
        rd_data_q[DBG_BOOT_BIT] <= boot_strap_q;
        rd_data_q[DBG_MONITOR_BIT] <= boot_monitor_active;
        rd_data_q[DBG_DONE_BIT] <= boot_seq_done;
      end
    end else begin
      rd_data_q <= '0;
    end
  end
  assign rd_data = rd_data_q;

  // ****************************************************************
  // boot strap sequence, reset only by pin or always-on power reset
  // ****************************************************************
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [MON_W-1:0] mon_cnt_q;
  logic boot_pin_lvl;
  assign boot_pin_lvl = pin_s2_q[BOOT_PIN_IDX];

  // other resets leave this state and the strap status untouched
  always_ff @(posedge sys_clk or negedge boot_qual_rst_n) begin
    if (!boot_qual_rst_n) begin
      boot_state_q <= BS_HOLD;
      hold_cnt_q <= '0;
      mon_cnt_q <= '0;
      boot_strap_q <= 1'b1;
      boot_monitor_active <= 1'b0;
    end else begin
      case (boot_state_q)
        BS_HOLD: begin
          if (fosc_tick) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
          end
          if (hold_cnt_q == HOLD_W'(HOLD_CYC)) begin
            boot_state_q <= BS_SAMPLE;
          end
        end
        BS_SAMPLE: begin
          boot_strap_q <= boot_pin_lvl;
          boot_monitor_active <= ~boot_pin_lvl;
          boot_state_q <= boot_pin_lvl ? BS_DONE : BS_CHECK;
        end
        BS_CHECK: begin
          mon_cnt_q <= mon_cnt_q + 1'b1;
          if (mon_cnt_q == MON_W'(MONITOR_CYC - 1)) begin
            boot_monitor_active <= ~boot_pin_lvl;
            boot_state_q <= BS_DONE;
          end
        end
        BS_DONE: begin
          boot_state_q <= BS_DONE;
        end
        default: begin
          boot_state_q <= BS_HOLD;
        end
      endcase
    end
  end
  assign boot_seq_done = (boot_state_q == BS_DONE);

  // ****************************************************************
  // pad drivers
  // ****************************************************************
  logic [PIN_CNT-1:0] pad_out_d;
  logic [PIN_CNT-1:0] pad_oe_d;
  logic [PIN_CNT-1:0] pad_pu_d;
  logic [PIN_CNT-1:0] pad_pd_d;

  // per-pin mode decode; the boot hold overrides the strap pin
  always_comb begin
    logic [CFG_W-1:0] mode;
    logic val;
    mode = '0;
    val = 1'b0;
    for (int i = 0; i < PIN_CNT; i++) begin
      mode = cfg_q[i*CFG_W +: CFG_W];
      is_analog[i] = (mode == CFG_ANALOG);
      in_lvl[i] = is_analog[i] ? 1'b1 : pin_s2_q[i];
      pad_out_d[i] = 1'b0;
      pad_oe_d[i] = 1'b0;
      pad_pu_d[i] = 1'b0;
      pad_pd_d[i] = 1'b0;
      val = (mode == CFG_ALT_PP || mode == CFG_ALT_OD) ? periph_out[i] : out_q[i];
      case (mode)
        CFG_IN_PULL: begin
          pad_pu_d[i] = out_q[i];
          pad_pd_d[i] = ~out_q[i];
        end
        CFG_OUT_PP, CFG_ALT_PP: begin
          pad_oe_d[i] = 1'b1;
          pad_out_d[i] = val;
        end
        CFG_OUT_OD, CFG_ALT_OD: begin
          pad_oe_d[i] = ~val;
          pad_out_d[i] = 1'b0;
        end
        default: begin
          pad_oe_d[i] = 1'b0;
        end
      endcase
    end
    // released to normal config once sampled
    if (boot_state_q == BS_HOLD || boot_state_q == BS_SAMPLE) begin
      pad_oe_d[BOOT_PIN_IDX] = 1'b0;
      pad_out_d[BOOT_PIN_IDX] = 1'b0;
      pad_pu_d[BOOT_PIN_IDX] = 1'b1;
      pad_pd_d[BOOT_PIN_IDX] = 1'b0;
    end
  end

  gpbw_pad_ctl_type pad_q;
  logic boot_pu_q;

  // registered pad controls and peripheral inputs: one cycle of latency
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pad_q <= '0;
      periph_in <= '0;
    end else begin
      pad_q.out <= pad_out_d;
      pad_q.oe <= pad_oe_d;
      pad_q.pu_en <= pad_pu_d;
      pad_q.pd_en <= pad_pd_d;
      periph_in <= in_lvl;
    end
  end

  // strap pull-up on the qualifying reset itself, so it is on while that reset is held
  always_ff @(posedge sys_clk or negedge boot_qual_rst_n) begin
    if (!boot_qual_rst_n) begin
      boot_pu_q <= 1'b1;
    end else begin
      boot_pu_q <= (boot_state_q == BS_HOLD) || (boot_state_q == BS_SAMPLE);
    end
  end

  // the general reset clears pad_q, so the strap pull is merged in after the flops
  assign pad_ctl = '{out: pad_q.out, oe: pad_q.oe, pd_en: pad_q.pd_en,
                     pu_en: pad_q.pu_en | (PIN_CNT'(boot_pu_q) << BOOT_PIN_IDX)};

  // ****************************************************************
  // wake monitor
  // ****************************************************************
  logic [SRC_CNT-1:0] src_lvl;
  logic [SRC_CNT-1:0] src_en;
  logic [SRC_CNT-1:0] src_filt;
  logic [SRC_CNT-1:0] cap_q;
  logic [SRC_CNT-1:0] h0_q;
  logic [SRC_CNT-1:0] h1_q;
  logic [SRC_CNT-1:0] h2_q;
  logic [SRC_CNT-1:0] hit;
  logic [1:0] smp_cnt_q;
  logic sleep_q;
  logic sleep_entry;

  assign src_lvl = {ext_s2_q, in_lvl};
  assign src_en = {sel_q[WSRC_IRQ4], sel_q[WSRC_SC2], sel_q[WSRC_SC1],
                   wake_en_q & ~is_analog & {PIN_CNT{sel_q[WSRC_PINS]}}};
  assign src_filt = {filt_q[WSRC_IRQ4], filt_q[WSRC_SC2], filt_q[WSRC_SC1], {PIN_CNT{filt_q[WSRC_PINS]}}};
  assign sleep_entry = deep_sleep & ~sleep_q;

  // capture levels at sleep entry and shift slow-clock samples while asleep
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_q <= 1'b0;
      cap_q <= '0;
      h0_q <= '0;
      h1_q <= '0;
      h2_q <= '0;
      smp_cnt_q <= '0;
    end else begin
      sleep_q <= deep_sleep;
      if (sleep_entry) begin
        cap_q <= src_lvl;
        smp_cnt_q <= '0;
      end else if (sleep_q && sosc_tick) begin
        h0_q <= src_lvl;
        h1_q <= h0_q;
        h2_q <= h1_q;
        if (smp_cnt_q != 2'(FILT_SAMPLES)) begin
          smp_cnt_q <= smp_cnt_q + 1'b1;
        end
      end
    end
  end

  // any difference counts, no edge selection; filtered needs three agreeing samples
  always_comb begin
    for (int i = 0; i < SRC_CNT; i++) begin
      if (src_filt[i]) begin
        hit[i] = (smp_cnt_q == 2'(FILT_SAMPLES)) && (h0_q[i] == h1_q[i]) &&
                 (h1_q[i] == h2_q[i]) && (h0_q[i] != cap_q[i]);
      end else begin
        hit[i] = (src_lvl[i] != cap_q[i]);
      end
      hit[i] = hit[i] & src_en[i] & sleep_q & ~sleep_entry;
    end
  end

  // only the class of source is recorded, not the pin
  assign wstat_set = {hit[PIN_CNT+2], hit[PIN_CNT+1], hit[PIN_CNT], |hit[PIN_CNT-1:0]};

  // wake request holds until the power manager leaves sleep
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_req <= 1'b0;
    end else if (!deep_sleep) begin
      wake_req <= 1'b0;
    end else if (|hit) begin
      wake_req <= 1'b1;
    end
  end
endmodule : gpbw_top

// ---- gpbw_monitor.sv ----
// gpbw_monitor: port-level assertions for the gpio pad, boot and wake block
`timescale 1ns/1ns
module gpbw_monitor
  import gpbw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire gpbw_pkg::gpbw_bus_req_type bus_req,
  input wire logic [gpbw_pkg::DATA_W-1:0] rd_data,
  input wire logic [gpbw_pkg::PIN_CNT-1:0] pad_in,
  input wire gpbw_pkg::gpbw_pad_ctl_type pad_ctl,
  input wire logic [gpbw_pkg::PIN_CNT-1:0] periph_in,
  input wire logic deep_sleep,
  input wire logic wake_req,
  input wire logic boot_monitor_active,
  input wire logic boot_seq_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [2:0] up_q;
  // cycles since reset; keeps $past away from pre-reset pin values
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence dbg_rd;
    bus_req.rd && bus_req.addr == OFS_DBG_STAT;
  endsequence
  sequence bad_rd;
    bus_req.rd && bus_req.addr == 8'h40;
  endsequence
  rd_idle_a: assert property (!bus_req.rd |=> rd_data == 32'h0) else $error("read data not idle");
  unmap_rd_a: assert property (bad_rd |=> rd_data == 32'h0) else $error("unmapped read not zero");
  dbg_read_a: assert property (dbg_rd |=> rd_data[2:1] == {$past(boot_seq_done), $past(boot_monitor_active)})
    else $error("boot status read wrong");
  drive_nopull_a: assert property ((pad_ctl.oe & (pad_ctl.pu_en | pad_ctl.pd_en)) == 8'h0)
    else $error("pull on a driven pin");
  pull_excl_a: assert property ((pad_ctl.pu_en & pad_ctl.pd_en) == 8'h0) else $error("both pulls on");
  pin_sync_a: assert property (up_q == 3'h7 && $past(pad_in, 2) == $past(pad_in, 3)
    && $past(pad_in, 3) == $past(pad_in, 4) |-> (~periph_in & $past(pad_in, 3)) == 8'h0) else $error("pin level lost");
  wake_clear_a: assert property (!deep_sleep |=> !wake_req) else $error("wake outside sleep");
  wake_sleep_a: assert property ($rose(wake_req) |-> $past(deep_sleep, 2)) else $error("wake before capture");
  boot_done_a: assert property (boot_seq_done |=> boot_seq_done) else $error("boot done lost");
  mon_stable_a: assert property (boot_seq_done && $past(boot_seq_done, 2) |-> $stable(boot_monitor_active))
    else $error("monitor flag moved");
endmodule : gpbw_monitor

bind gpbw_top gpbw_monitor gpbw_monitor_inst (.sys_clk, .nrst, .bus_req, .rd_data, .pad_in, .pad_ctl, .periph_in,
  .deep_sleep, .wake_req, .boot_monitor_active, .boot_seq_done);

// ---- gpbw_pad_model.sv ----
// gpbw_pad_model: external circuit on the port pins
`timescale 1ns/1ns
module gpbw_pad_model
  import gpbw_pkg::*;
(
  input wire logic sys_clk,
  input wire gpbw_pkg::gpbw_pad_ctl_type pad_ctl,
  input wire logic [gpbw_pkg::PIN_CNT-1:0] ext_en,
  input wire logic [gpbw_pkg::PIN_CNT-1:0] ext_val,
  output logic [gpbw_pkg::PIN_CNT-1:0] pad_in
);
  logic [PIN_CNT-1:0] float_q = 8'h00;
  // an undriven pin wanders, so a missing pull never reads as a clean level
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end
  // device drive first, then the far side, then the pulls
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      if (pad_ctl.oe[i]) begin
        pad_in[i] = pad_ctl.out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_ctl.pu_en[i] | pad_ctl.pd_en[i]) begin
        pad_in[i] = pad_ctl.pu_en[i];
      end else begin
        pad_in[i] = float_q[i];
      end
    end
  end
endmodule : gpbw_pad_model

// ---- tb.sv ----
// tb: self-checking bench for the gpio pad, boot and wake block
`timescale 1ns/1ns
module tb;
  import gpbw_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic qrst_n = 1'b0;
  logic fosc = 1'b0;
  logic sosc = 1'b0;
  gpbw_bus_req_type req = '0;
  gpbw_pad_ctl_type pad_ctl;
  logic [DATA_W-1:0] rd_data;
  logic [PIN_CNT-1:0] pad_in, periph_in, periph_out = 8'h00, ext_en = 8'h20, ext_val = 8'h00;
  logic sc1 = 1'b0, sc2 = 1'b0, irq4 = 1'b0, sleep = 1'b0, wake, mon, done;
  int err_total = 0;
  int num_checks = 0;
  // fast oscillator unrelated to sys_clk; slow one scaled down from 10 kHz
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always #11 fosc = ~fosc;
  always #200 sosc = ~sosc;
  gpbw_top #(.MONITOR_CYC(40), .HOLD_CYC(4)) gpbw_top_inst (.sys_clk, .nrst, .boot_qual_rst_n(qrst_n),
    .fast_rc_oscillator(fosc), .slow_rc_oscillator(sosc), .bus_req(req), .rd_data, .pad_in, .pad_ctl,
    .periph_out, .periph_in, .serial_one_activity(sc1), .serial_two_activity(sc2), .irq_four_in(irq4),
    .deep_sleep(sleep), .wake_req(wake), .boot_monitor_active(mon), .boot_seq_done(done));
  gpbw_pad_model gpbw_pad_model_inst (.sys_clk, .pad_ctl, .ext_en, .ext_val, .pad_in);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one gap cycle after each strobe so req is never assigned twice per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    req <= '0;
    #1 d = rd_data;
    chk(d & m, e);
    @(posedge sys_clk);
  endtask : rdc
  task automatic boot(input logic qual, input int rel, input logic [DATA_W-1:0] e);
    nrst <= 1'b0;
    qrst_n <= ~qual;
    ext_val[5] <= ~qual;
    repeat (12) @(posedge sys_clk);
    chk(32'({pad_ctl.pu_en[5], pad_ctl.oe[5]}), qual ? 32'h2 : 32'h0);
    nrst <= 1'b1;
    qrst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'({pad_ctl.pu_en[5], pad_ctl.oe[5]}), qual ? 32'h2 : 32'h0);
    for (int i = 0; i < 300 && done !== 1'b1; i++) begin
      if (i == rel) ext_val[5] <= 1'b1;
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
    chk(32'(pad_ctl.pu_en[5]), 32'h0);
    chk(32'(mon), 32'(e[1]));
    rdc(OFS_DBG_STAT, 32'h7, e);
  endtask : boot
  // src 0 pin 2, 1..3 serial one, serial two, irq four; 4 disturbs nothing
  task automatic wake_try(input int src, input logic [3:0] sel, input logic [3:0] filt, input int pulse,
    input logic exp);
    wr(OFS_WAKE_SEL, 32'(sel));
    wr(OFS_WAKE_FILT, 32'(filt));
    sleep <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int k = 0; k < 2; k++) begin
      case (src)
        0: ext_val[2] <= ~ext_val[2];
        1: sc1 <= ~sc1;
        2: sc2 <= ~sc2;
        3: irq4 <= ~irq4;
        default: ;
      endcase
      if (pulse == 0) break;
      repeat (pulse) @(posedge sys_clk);
    end
    for (int i = 0; i < 600 && wake !== 1'b1; i++) @(posedge sys_clk);
    chk(32'(wake), 32'(exp));
    rdc(OFS_WAKE_STAT, 32'hF, exp ? 32'(1 << src) : 32'h0);
    sleep <= 1'b0;
    // let the sleep flag drop first, or a still-live hit sets the status again over the clear
    @(posedge sys_clk);
    wr(OFS_WAKE_STAT, 32'hF);
  endtask : wake_try
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // hang guard, far beyond the expected run of under 10000 cycles
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    boot(1'b1, 299, 32'h6);
    boot(1'b1, 45, 32'h4);
    boot(1'b0, 0, 32'h4);
    $display("boot tests ended");
    wr(OFS_PORT_CFG, 32'h16150243);
    periph_out <= 8'h10;
    ext_en <= 8'h22;
    ext_val <= 8'h20;
    wr(OFS_PORT_OUT, 32'h05);
    repeat (4) @(posedge sys_clk);
    chk({pad_ctl.oe, pad_ctl.out & pad_ctl.oe, pad_ctl.pu_en, pad_ctl.pd_en}, 32'h53110400);
    chk(32'(periph_in & 8'h7F), 32'h3D);
    rdc(OFS_PORT_IN, 32'h7F, 32'h3D);
    periph_out <= 8'h40;
    wr(OFS_PORT_CLR, 32'h04);
    wr(OFS_PORT_SET, 32'h02);
    repeat (4) @(posedge sys_clk);
    chk({pad_ctl.oe, pad_ctl.out & pad_ctl.oe, pad_ctl.pu_en, pad_ctl.pd_en}, 32'h11010004);
    rdc(OFS_PORT_OUT, 32'hFFFFFFFF, 32'h03);
    rdc(OFS_PORT_IN, 32'h0F, 32'h09);
    rdc(OFS_PORT_CFG, 32'hFFFFFFFF, 32'h16150243);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0);
    $display("pad tests ended");
    ext_en <= 8'h26;
    ext_val <= 8'h24;
    wr(OFS_WAKE_EN, 32'h0C);
    wake_try(0, 4'h1, 4'h0, 0, 1'b1);
    wake_try(0, 4'h1, 4'h0, 0, 1'b1);
    wake_try(4, 4'h1, 4'h0, 0, 1'b0);
    wake_try(0, 4'h0, 4'h0, 0, 1'b0);
    wake_try(1, 4'h2, 4'h0, 0, 1'b1);
    wake_try(2, 4'h4, 4'h0, 0, 1'b1);
    wake_try(3, 4'h8, 4'h8, 50, 1'b0);
    wake_try(3, 4'h8, 4'h8, 0, 1'b1);
    wake_try(0, 4'h1, 4'h1, 0, 1'b1);
    $display("wake tests ended");
    final_report();
  end
endmodule : tb
